// File: common/dpx_map.svh
// Purpose: Offsets, field positions, reset values and fixed words of the port expander.
// Assumes: Included by its bare name from the core, the checker and the bench.
// Notes: Register offsets are byte addresses on the 32-bit register bus.
`ifndef DPX_MAP_SVH
`define DPX_MAP_SVH

// Register byte offsets
`define DPX_OFF_CTRL 8'h00
`define DPX_OFF_STATUS 8'h04

// Control register fields
`define DPX_CTRL_EN_BIT 0
`define DPX_CTRL_RESET 32'h0000_0001

// Status register field positions
`define DPX_ST_IRQ_LSB 0
`define DPX_ST_GNT_LSB 8
`define DPX_ST_SGNT_BIT 16
`define DPX_ST_SREQ_BIT 17
`define DPX_ST_REARM_LSB 18

// Fixed memory word the interrupt word is written to
`define DPX_IRQ_WORD_ADDR 16'h0096
`define DPX_WORD_ZERO 16'h0000

// Bus responses
`define DPX_RESP_OKAY 2'b00
`define DPX_RESP_SLVERR 2'b10

// Idle count that sets the load enable one clock later, three clocks after grant OR falls
`define DPX_LOAD_GAP 2'd2

`endif

// File: common/dpx_pkg.sv
// Purpose: Types shared by the port expander and its bench.
// Assumes: AXI4-Lite register bus with 8-bit addresses and 32-bit data.
// Notes: Constants live in dpx_map.svh.
package dpx_pkg;

  // Master to slave signals of the register bus
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } dpx_axil_req_t;

  // Slave to master signals of the register bus
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } dpx_axil_rsp_t;

  // Memory side of the interrupt word store
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } dpx_mem_word_t;

  // Phases of the interrupt word store cycle
  typedef enum logic [2:0] {
    DPX_ST_IDLE = 3'b000,
    DPX_ST_REQ = 3'b001,
    DPX_ST_GRANT = 3'b010,
    DPX_ST_PULSE = 3'b011,
    DPX_ST_DONE = 3'b100
  } dpx_store_t;

endpackage

// File: core/dpx_arbiter.sv
// Purpose: Expands one host DMA port into eight prioritised channels plus interrupt word store.
// Assumes: Host grant, interrupt acknowledge and cycle start are synchronous to clk_in;
//   channel request and interrupt lines are asynchronous.
// Notes: Software sees a control and a status register over AXI4-Lite.
//
// Overview of operation
// - Host request when any channel requests
// - Store request outranks every channel request
// - Host grant goes to one top requester
// - Channel zero highest, seven lowest priority
// - Pending store request takes the grant first
// - Released synchronised request clears channel grant
// - Check pulse two clocks after cycle start
// - Check pulse revokes grant for higher request
// - No lower grant while holder keeps request
// - Grant OR blocks every new grant
// - Three idle clocks, load enable, then grant
// - Host request stays while channels request
// - Line sets capture bit, deferred during store
// - Rearm clears after capture until released
// - Summary interrupt held until host acknowledge
// - Host acknowledge raises store request
// - Capture bits on write data, upper zero
// - Store cycle drives fixed word address
// - Store pulse one clock after store grant
// - Acknowledge only channels in stored word
// - Done pulse, then clear capture and store
// - Stored line ignored until it drops
`timescale 1ns/1ns
`include "dpx_map.svh"

module dpx_arbiter #(
  parameter int NUM_CHAN = 8
) (
  input wire logic clk_in,                               // System clock, 125 MHz
  input wire logic rst_n_in,                             // Synchronous reset, active low
  input wire logic [NUM_CHAN-1:0] chan_mem_req_in,       // Channel memory requests, async
  input wire logic [NUM_CHAN-1:0] chan_irq_line_in,      // Channel interrupt lines, async
  input wire logic host_grant_in,                        // Host memory access grant
  input wire logic host_irq_ack_in,                      // Host interrupt acknowledge
  input wire logic mem_cycle_start_in,                   // Store or fetch cycle start pulse
  output logic host_mem_req_out,                         // Merged request to host
  output logic [NUM_CHAN-1:0] chan_access_grant_out,     // Per-channel access grants
  output logic irq_store_grant_out,                      // Grant held by store logic
  output logic irq_summary_out,                          // Interrupt request to host
  output logic irq_word_write_pulse_out,                 // One-clock store pulse
  output logic irq_cycle_done_out,                       // One-clock store complete
  output logic [NUM_CHAN-1:0] chan_irq_ack_out,          // One-clock channel acknowledges
  output dpx_pkg::dpx_mem_word_t mem_word_out,           // Store address and write data
  input wire dpx_pkg::dpx_axil_req_t axil_req_in,        // Register bus, master side
  output dpx_pkg::dpx_axil_rsp_t axil_rsp_out            // Register bus, slave side
);
  import dpx_pkg::*;

  // Lowest set bit wins; shared by channel pick and pre-emption test
  function automatic logic [NUM_CHAN-1:0] pick_top(input logic [NUM_CHAN-1:0] req);
    logic [NUM_CHAN-1:0] one;
    one = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        one = '0;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction

  logic [NUM_CHAN-1:0] req_s1_r;
  logic [NUM_CHAN-1:0] req_s_r;
  logic [NUM_CHAN-1:0] line_s1_r;
  logic [NUM_CHAN-1:0] line_s_r;
  logic [NUM_CHAN-1:0] grant_r;
  logic [NUM_CHAN-1:0] priority_tree_out;
  logic [NUM_CHAN-1:0] irq_capture_reg_r;
  logic [NUM_CHAN-1:0] irq_line_rearm_r;
  logic [NUM_CHAN-1:0] ack_r;
  logic [1:0] idle_cnt_r;
  logic grant_load_enable_r;
  logic start_d1_r;
  logic change_r;
  logic any_grant_active;
  logic load_now;
  logic ctrl_en_r;
  logic irq_store_req;
  logic irq_store_grant;
  dpx_store_t st_r;
  dpx_store_t st_nxt;
  dpx_mem_word_t word_r;

  // Two flip-flops per asynchronous line; only the second is read
  // input synchronisers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      req_s1_r <= '0;
      req_s_r <= '0;
      line_s1_r <= '0;
      line_s_r <= '0;
    end
    else
    begin
      req_s1_r <= chan_mem_req_in;
      req_s_r <= req_s1_r;
      line_s1_r <= chan_irq_line_in;
      line_s_r <= line_s1_r;
    end
  end

  // Fixed priority: channel 0 first
  // fixed channel order
  assign priority_tree_out = pick_top(req_s_r);

  // Store phases hold the request and the grant
  assign irq_store_req = (st_r != DPX_ST_IDLE);
  assign irq_store_grant = (st_r == DPX_ST_GRANT) || (st_r == DPX_ST_PULSE) || (st_r == DPX_ST_DONE);

  assign any_grant_active = (|grant_r) | irq_store_grant;

  // New grant only with host grant, load enable and nothing held
  // grant after load enable
  assign load_now = grant_load_enable_r & host_grant_in & ~any_grant_active;

  // Merged host request; the enable lets software park the port
  // merged host request
  assign host_mem_req_out = ctrl_en_r & ((|req_s_r) | irq_store_req);

  // Idle gap counter; a grant restarts it so no grant follows too closely
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      idle_cnt_r <= 2'd0;
      grant_load_enable_r <= 1'b0;
    end
    else if (any_grant_active || load_now)
    begin
      idle_cnt_r <= 2'd0;
      grant_load_enable_r <= 1'b0;
    end
    else
    begin
      if (idle_cnt_r != `DPX_LOAD_GAP)
      begin
        idle_cnt_r <= idle_cnt_r + 2'd1;
      end
      grant_load_enable_r <= (idle_cnt_r == `DPX_LOAD_GAP);
    end
  end

  // Pre-emption check pulse on the second clock after a cycle start
  // delayed check pulse
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      start_d1_r <= 1'b0;
      change_r <= 1'b0;
    end
    else
    begin
      start_d1_r <= mem_cycle_start_in;
      change_r <= start_d1_r;
    end
  end

  // One grant flip-flop per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_chan
      logic [NUM_CHAN-1:0] higher;
      assign higher = NUM_CHAN'((1 << g) - 1);
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          grant_r[g] <= 1'b0;
        end
        else if (grant_r[g] && !req_s_r[g])
        begin
          grant_r[g] <= 1'b0;
        end
        else if (grant_r[g] && change_r && |(priority_tree_out & higher))
        begin
          grant_r[g] <= 1'b0;
        end
        else if (load_now && !irq_store_req && priority_tree_out[g])
        begin
          grant_r[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign chan_access_grant_out = grant_r;
  assign irq_store_grant_out = irq_store_grant;

  // Store cycle sequence
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      DPX_ST_IDLE:
      begin
        if (host_irq_ack_in && |irq_capture_reg_r)
        begin
          st_nxt = DPX_ST_REQ;
        end
      end
      DPX_ST_REQ:
      begin
        if (load_now)
        begin
          st_nxt = DPX_ST_GRANT;
        end
      end
      DPX_ST_GRANT:
        st_nxt = DPX_ST_PULSE;
      DPX_ST_PULSE:
        st_nxt = DPX_ST_DONE;
      DPX_ST_DONE:
        st_nxt = DPX_ST_IDLE;
      default:
        st_nxt = DPX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= DPX_ST_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign irq_word_write_pulse_out = (st_r == DPX_ST_PULSE);
  // done pulse as store pulse ends
  assign irq_cycle_done_out = (st_r == DPX_ST_DONE);

  // Interrupt capture and rearm flags; a set blocked by the store grant waits for it to drop
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_capture_reg_r <= '0;
      irq_line_rearm_r <= '1;
    end
    else
    begin
      for (int n = 0; n < NUM_CHAN; n++)
      begin
        if (st_r == DPX_ST_DONE)
        begin
          irq_capture_reg_r[n] <= 1'b0;
        end
        else if (line_s_r[n] && irq_line_rearm_r[n] && !irq_store_grant)
        begin
          irq_capture_reg_r[n] <= 1'b1;
        end
        if (irq_capture_reg_r[n])
        begin
          irq_line_rearm_r[n] <= 1'b0;
        end
        else if (!line_s_r[n])
        begin
          irq_line_rearm_r[n] <= 1'b1;
        end
      end
    end
  end

  // Summary falls once the host has acknowledged
  // summary until acknowledge
  assign irq_summary_out = (|irq_capture_reg_r) & ~irq_store_req;

  // Acknowledges and memory word come from flip-flops
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ack_r <= '0;
      word_r <= '0;
    end
    else
    begin
      ack_r <= (st_r == DPX_ST_PULSE) ? irq_capture_reg_r : '0;
      // Word is stable from the pulse through done; zero otherwise
      if (st_nxt == DPX_ST_PULSE || st_nxt == DPX_ST_DONE)
      begin
        word_r.addr <= `DPX_IRQ_WORD_ADDR;
        word_r.data <= {{(16 - NUM_CHAN){1'b0}}, irq_capture_reg_r};
      end
      else
      begin
        word_r <= '0;
      end
    end
  end

  assign chan_irq_ack_out = ack_r;
  assign mem_word_out = word_r;

  // Register bus slave: address and data accepted in either order
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] status_word;

  assign axil_rsp_out.awready = ~aw_got_r & ~bvalid_r;
  assign axil_rsp_out.wready = ~w_got_r & ~bvalid_r;
  assign axil_rsp_out.bvalid = bvalid_r;
  assign axil_rsp_out.bresp = bresp_r;
  assign axil_rsp_out.arready = ~rvalid_r;
  assign axil_rsp_out.rvalid = rvalid_r;
  assign axil_rsp_out.rdata = rdata_r;
  assign axil_rsp_out.rresp = rresp_r;

  // Status shows live arbitration and interrupt state
  always_comb
  begin
    status_word = '0;
    status_word[`DPX_ST_IRQ_LSB +: NUM_CHAN] = irq_capture_reg_r;
    status_word[`DPX_ST_GNT_LSB +: NUM_CHAN] = grant_r;
    status_word[`DPX_ST_SGNT_BIT] = irq_store_grant;
    status_word[`DPX_ST_SREQ_BIT] = irq_store_req;
    status_word[`DPX_ST_REARM_LSB +: NUM_CHAN] = irq_line_rearm_r;
  end

  // Write channel capture and response
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `DPX_RESP_OKAY;
      ctrl_en_r <= 1'b1;
    end
    else
    begin
      if (axil_req_in.awvalid && axil_rsp_out.awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= axil_req_in.awaddr;
      end
      if (axil_req_in.wvalid && axil_rsp_out.wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= axil_req_in.wdata;
        wstrb_r <= axil_req_in.wstrb;
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        if (awaddr_r == `DPX_OFF_CTRL)
        begin
          bresp_r <= `DPX_RESP_OKAY;
          if (wstrb_r[0])
          begin
            ctrl_en_r <= wdata_r[`DPX_CTRL_EN_BIT];
          end
        end
        else if (awaddr_r == `DPX_OFF_STATUS)
        begin
          bresp_r <= `DPX_RESP_OKAY; // Status is read-only; write ignored
        end
        else
        begin
          bresp_r <= `DPX_RESP_SLVERR;
        end
      end
      else if (bvalid_r && axil_req_in.bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `DPX_RESP_OKAY;
    end
    else if (axil_req_in.arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      if (axil_req_in.araddr == `DPX_OFF_CTRL)
      begin
        rdata_r <= {31'h0000_0000, ctrl_en_r};
        rresp_r <= `DPX_RESP_OKAY;
      end
      else if (axil_req_in.araddr == `DPX_OFF_STATUS)
      begin
        rdata_r <= status_word;
        rresp_r <= `DPX_RESP_OKAY;
      end
      else
      begin
        rdata_r <= '0;
        rresp_r <= `DPX_RESP_SLVERR;
      end
    end
    else if (rvalid_r && axil_req_in.rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// File: sim/dpx_arbiter_sva.sv
// Purpose: Checker for arbitration and interrupt store of the port expander.
// Assumes: Bound to dpx_arbiter and sees its ports only.
// Notes: Channel pins are watched raw, so delays include the synchroniser.
`timescale 1ns/1ns
`include "dpx_map.svh"
module dpx_arbiter_sva #(
  parameter int NUM_CHAN = 8
) (
  input wire logic clk_in,                           // System clock
  input wire logic rst_n_in,                         // Reset, active low
  input wire logic [NUM_CHAN-1:0] chan_mem_req_in,   // Raw requests
  input wire logic host_irq_ack_in,                  // Host acknowledge
  input wire logic host_mem_req_out,                 // Host request
  input wire logic [NUM_CHAN-1:0] chan_access_grant_out, // Grants
  input wire logic irq_store_grant_out,              // Store grant
  input wire logic irq_summary_out,                  // Summary interrupt
  input wire logic irq_word_write_pulse_out,         // Store pulse
  input wire logic irq_cycle_done_out,               // Done pulse
  input wire logic [NUM_CHAN-1:0] chan_irq_ack_out,  // Channel acks
  input wire dpx_pkg::dpx_mem_word_t mem_word_out    // Store word
);
  import dpx_pkg::*;
  // Any grant held, and grants whose pin has already dropped
  wire logic any_g = |{chan_access_grant_out, irq_store_grant_out};
  wire logic [NUM_CHAN-1:0] gnt_rel = chan_access_grant_out & ~chan_mem_req_in;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_req;
    (|chan_mem_req_in) [*3] |-> host_mem_req_out;
  endproperty
  a_req: assert property (p_req)
    else $error("host request missing");
  property p_one;
    $onehot0({chan_access_grant_out, irq_store_grant_out});
  endproperty
  a_one: assert property (p_one)
    else $error("more than one grant");
  property p_gap;
    $fell(any_g) |=> !any_g [*3];
  endproperty
  a_gap: assert property (p_gap)
    else $error("grant too soon after release");
  property p_rel;
    (gnt_rel != '0) [*3] |=> gnt_rel == '0;
  endproperty
  a_rel: assert property (p_rel)
    else $error("grant kept after release");
  property p_ack;
    irq_summary_out && host_irq_ack_in |=> !irq_summary_out && host_mem_req_out;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge did not start store");
  property p_hold;
    irq_summary_out && !host_irq_ack_in |=> irq_summary_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("summary dropped early");
  property p_pulse;
    $rose(irq_store_grant_out) |=> irq_word_write_pulse_out;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("store pulse late");
  property p_done;
    irq_word_write_pulse_out |=> irq_cycle_done_out && !irq_word_write_pulse_out;
  endproperty
  a_done: assert property (p_done)
    else $error("pulse length or done wrong");
  property p_word;
    irq_word_write_pulse_out |-> mem_word_out.addr == `DPX_IRQ_WORD_ADDR && mem_word_out.data[15:8] == 8'h00;
  endproperty
  a_word: assert property (p_word)
    else $error("store word wrong");
  property p_acks;
    irq_cycle_done_out |-> chan_irq_ack_out == mem_word_out.data[NUM_CHAN-1:0] && chan_irq_ack_out != '0;
  endproperty
  a_acks: assert property (p_acks)
    else $error("acks differ from word");
  property p_noack;
    !irq_cycle_done_out |-> chan_irq_ack_out == '0;
  endproperty
  a_noack: assert property (p_noack)
    else $error("stray channel ack");
  property p_clr;
    irq_cycle_done_out |=> !irq_store_grant_out && !irq_summary_out;
  endproperty
  a_clr: assert property (p_clr)
    else $error("store not cleared");
  // Main scenarios reached
  c_store: cover property (irq_cycle_done_out);
  c_gap: cover property ($fell(any_g));
  c_ack: cover property (irq_summary_out && host_irq_ack_in);
endmodule

bind dpx_arbiter dpx_arbiter_sva #(.NUM_CHAN(NUM_CHAN)) u_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .chan_mem_req_in(chan_mem_req_in),
  .host_irq_ack_in(host_irq_ack_in), .host_mem_req_out(host_mem_req_out),
  .chan_access_grant_out(chan_access_grant_out), .irq_store_grant_out(irq_store_grant_out),
  .irq_summary_out(irq_summary_out), .irq_word_write_pulse_out(irq_word_write_pulse_out),
  .irq_cycle_done_out(irq_cycle_done_out), .chan_irq_ack_out(chan_irq_ack_out),
  .mem_word_out(mem_word_out));

// File: sim/dpx_host_model.sv
// Purpose: Host memory controller model for the port expander.
// Assumes: Grants follow the merged request, promptly or one clock late.
// Notes: Acknowledges only when the bench allows it.
`timescale 1ns/1ns
module dpx_host_model (
  input wire logic clk_in,         // System clock
  input wire logic rst_n_in,       // Reset, active low
  input wire logic req_in,         // Merged request
  input wire logic [7:0] grant_in, // Channel grants
  input wire logic summary_in,     // Interrupt request
  input wire logic ack_en_in,      // Acknowledge allowed
  input wire logic slow_in,        // Late grants
  output logic grant_out,          // Memory grant
  output logic ack_out,            // Interrupt acknowledge
  output logic start_out           // Cycle start pulse
);
  logic req_d_r;
  logic [2:0] cnt_r;
  // Grant tracks request; slow mode adds a clock so load timing is stressed
  always_ff @(posedge clk_in)
  begin
    req_d_r <= rst_n_in & req_in;
    grant_out <= rst_n_in & req_in & (req_d_r | ~slow_in);
  end
  // A cycle starts every eight clocks while a channel holds access
  always_ff @(posedge clk_in)
  begin
    cnt_r <= (rst_n_in && |grant_in) ? cnt_r + 3'd1 : 3'd0;
    start_out <= rst_n_in && |grant_in && cnt_r == 3'd1;
  end
  // One-clock acknowledge; never repeated back to back
  always_ff @(posedge clk_in)
    ack_out <= rst_n_in & ack_en_in & summary_in & ~ack_out;
endmodule

// File: sim/tb.sv
// Purpose: Self-checking bench for the port expander arbiter.
// Assumes: Host side is the model; channels are driven here.
// Notes: Inputs change at rising edges; outputs are read at falling edges, register bus responses at rising edges.
`timescale 1ns/1ns
`include "dpx_map.svh"
module tb;
  import dpx_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] req = 8'h00;
  logic [7:0] irq = 8'h00;
  logic ack_en = 1'b0;
  logic slow = 1'b0;
  logic hgnt, hack, cstart, hreq, sgnt, summ, pulse, done;
  logic [7:0] gnt, iack, expg;
  dpx_mem_word_t mw;
  dpx_axil_req_t axq = '0;
  dpx_axil_rsp_t axs;
  logic [1:0] resp;
  logic [31:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  // Clock, 8 ns period
  always #4 clk_in = ~clk_in;
  dpx_arbiter dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .chan_mem_req_in(req), .chan_irq_line_in(irq),
    .host_grant_in(hgnt), .host_irq_ack_in(hack), .mem_cycle_start_in(cstart), .host_mem_req_out(hreq),
    .chan_access_grant_out(gnt), .irq_store_grant_out(sgnt), .irq_summary_out(summ),
    .irq_word_write_pulse_out(pulse), .irq_cycle_done_out(done), .chan_irq_ack_out(iack),
    .mem_word_out(mw), .axil_req_in(axq), .axil_rsp_out(axs));
  dpx_host_model u_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(hreq), .grant_in(gnt),
    .summary_in(summ), .ack_en_in(ack_en), .slow_in(slow), .grant_out(hgnt), .ack_out(hack),
    .start_out(cstart));
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic give_up();
    fail_count++;
    complete_run();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Wait conditions, looked at on falling edges
  function automatic logic cond(input int k);
    case (k)
      1: cond = summ === 1'b1;
      2: cond = sgnt === 1'b1;
      3: cond = pulse === 1'b1;
      4: cond = summ === 1'b0;
      default: cond = gnt !== 8'h00 && gnt !== expg;
    endcase
  endfunction
  task automatic wt(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (!cond(k) && n < 300);
    if (!cond(k))
      give_up();
  endtask
  task automatic drv(input logic [7:0] r, input logic [7:0] q);
    @(posedge clk_in);
    req <= r;
    irq <= q;
  endtask
  // Register bus: each channel released at the edge that takes it
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    axq.awaddr <= a;
    axq.awvalid <= 1'b1;
    axq.wdata <= d;
    axq.wstrb <= 4'hf;
    axq.wvalid <= 1'b1;
    axq.bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_in);
      if (axs.awready) axq.awvalid <= 1'b0;
      if (axs.wready) axq.wvalid <= 1'b0;
      if (axs.bvalid)
      begin
        resp = axs.bresp;
        axq.bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      give_up();
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clk_in);
    axq.araddr <= a;
    axq.arvalid <= 1'b1;
    axq.rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_in);
      if (axs.arready) axq.arvalid <= 1'b0;
      if (axs.rvalid)
      begin
        rd = axs.rdata;
        resp = axs.rresp;
        axq.rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      give_up();
  endtask
  task automatic t_regs();
    axr(8'h04);
    chk("status at reset", rd, 32'h03fc_0000);
    // Park the port and read it back while no channel asks
    axw(8'h00, 32'h0000_0000);
    axr(8'h00);
    chk("ctrl off", rd, 32'h0000_0000);
    axw(8'h00, 32'h0000_0001);
    chk("ctrl write resp", resp, `DPX_RESP_OKAY);
    axr(8'h00);
    chk("ctrl", rd, 32'h0000_0001);
    axw(8'h04, 32'hffff_ffff);
    chk("status write resp", resp, `DPX_RESP_OKAY);
    axr(8'h04);
    chk("status after write", rd, 32'h03fc_0000);
    axr(8'h10);
    chk("unmapped resp", resp, `DPX_RESP_SLVERR);
    chk("unmapped data", rd, 32'h0000_0000);
  endtask
  // Three waiting channels, a pre-emption, then release in priority order
  task automatic t_prio();
    int i;
    logic [7:0] order [5] = '{8'h04, 8'h01, 8'h04, 8'h20, 8'h80};
    @(posedge clk_in) slow <= 1'b1;
    expg = 8'h00;
    drv(8'ha4, 8'h00);
    for (i = 0; i < 5; i++)
    begin
      wt(0);
      chk("grant", gnt, order[i]);
      expg = gnt;
      if (i == 0)
      begin
        repeat (20) @(negedge clk_in);
        chk("holder kept", gnt, 8'h04);
        drv(8'ha5, 8'h00);
      end
      else
        drv(req & ~gnt, 8'h00);
    end
    repeat (6) @(negedge clk_in);
    chk("host request idle", hreq, 1'b0);
    @(posedge clk_in) slow <= 1'b0;
  endtask
  // Store outranks a waiting channel; late and held lines
  task automatic t_irq();
    expg = 8'h00;
    drv(8'h10, 8'h42);
    wt(0);
    wt(1);
    axr(8'h04);
    chk("captured", rd, 32'h02f4_1042);
    @(posedge clk_in) ack_en <= 1'b1;
    wt(4);
    @(posedge clk_in) ack_en <= 1'b0;
    drv(8'h01, 8'h42);
    // Line 3 reaches the synchroniser output as the store grant sets, so only deferral keeps it out
    repeat (4) @(posedge clk_in);
    drv(8'h01, 8'h4a);
    wt(2);
    chk("channels held off", gnt, 8'h00);
    wt(3);
    chk("store word", mw, 32'h0096_0042);
    @(negedge clk_in);
    chk("done and acks", {done, iack}, 32'h0000_0142);
    wt(0);
    chk("grant after store", {sgnt, gnt}, 32'h0000_0001);
    drv(8'h00, 8'h4a);
    repeat (10) @(negedge clk_in);
    axr(8'h04);
    chk("deferred and held", rd, 32'h02d4_0008);
    drv(8'h00, 8'h08);
    repeat (6) @(negedge clk_in);
    drv(8'h00, 8'h4a);
    repeat (6) @(negedge clk_in);
    axr(8'h04);
    chk("rearmed", rd[7:0], 8'h4a);
    @(posedge clk_in) ack_en <= 1'b1;
    wt(4);
    @(posedge clk_in) ack_en <= 1'b0;
    drv(8'h00, 8'h00);
    repeat (20) @(negedge clk_in);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_prio();
    t_irq();
    complete_run();
  end
endmodule
